// ### hw/ais_pkg.sv
// package: register map, field layout and constants of the input-select block
package ais_pkg;
  localparam logic [11:0] AIS_OFF_INPUT_SELECT = 12'h000;
  localparam logic [11:0] AIS_OFF_PCFG_LOW = 12'h004;
  localparam logic [11:0] AIS_OFF_PCFG_HIGH = 12'h008;
  localparam logic [11:0] AIS_OFF_SCAN_LOW = 12'h00C;
  localparam logic [11:0] AIS_OFF_SCAN_HIGH = 12'h010;
  localparam logic [11:0] AIS_OFF_CONTROL = 12'h014;
  localparam logic [11:0] AIS_OFF_STATUS = 12'h018;
  localparam logic [15:0] AIS_MASK_INPUT_SELECT = 16'h9F9F;
  localparam logic [15:0] AIS_MASK_HIGH = 16'h0003;
  localparam logic [15:0] AIS_MASK_CONTROL = 16'h03FF;
  localparam logic [15:0] AIS_RESET_VALUE = 16'h0000;
  localparam int AIS_NEG_B_BIT = 15;
  localparam int AIS_NEG_A_BIT = 7;
  localparam int AIS_POS_B_LSB = 8;
  localparam int AIS_POS_A_LSB = 0;
  localparam int AIS_SCAN_EN_BIT = 8;
  localparam int AIS_ALT_BIT = 9;
  localparam logic [4:0] AIS_CODE_HALF_GAP = 5'h1E;
  localparam logic [4:0] AIS_CODE_FULL_GAP = 5'h1F;
  localparam logic [4:0] AIS_CODE_MAX_PIN = 5'h0F;
  // channel index 16 = half gap, 17 = full gap
  localparam logic [4:0] AIS_CH_HALF_GAP = 5'h10;
  localparam logic [4:0] AIS_CH_FULL_GAP = 5'h11;
  localparam int AIS_NUM_CH = 18;
endpackage

// ### hw/ais_clk_div.sv
// conversion clock divider: period is (divider + 1) instruction cycles
`timescale 1ns/1ns
module ais_clk_div (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [7:0] divider,
  output logic tick
);
  logic [7:0] count_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 8'h00;
      tick <= 1'b0;
    end else if (!enable) begin
      count_reg <= 8'h00;
      tick <= 1'b0;
    end else if (count_reg >= divider) begin
      count_reg <= 8'h00;
      tick <= 1'b1;
    end else begin
      count_reg <= count_reg + 8'h01;
      tick <= 1'b0;
    end
  end

  chk_tick_spacing: assert property (
    @(posedge pclk) disable iff (!presetn)
    tick && enable && divider == 8'h01 && $stable(divider) |=>
    !tick ##1 (tick || !enable || divider != 8'h01 || $changed(divider)))
    else $error("tick spacing wrong for divider one");
endmodule

// ### hw/ais_top.sv
// input select, pin config, scan sequencing and conversion clock over APB
`timescale 1ns/1ns
module ais_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic sample_done,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [4:0] positive_channel,
  output logic negative_is_input1,
  output logic [15:0] pin_digital_mode_bits,
  output logic [15:0] pin_analog_sample_en,
  output logic conv_clock_tick
);
  logic [15:0] input_select_reg;
  logic [15:0] pin_analog_config_low_reg;
  logic [15:0] pin_analog_config_high_reg;
  logic [15:0] scan_select_low_reg;
  logic [15:0] scan_select_high_reg;
  logic [15:0] control_reg;
  logic [4:0] scan_ch_reg;
  logic [4:0] scan_ch_next;
  logic [4:0] scan_cur;
  logic use_b_reg;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [17:0] scan_set;
  logic tick_int;
  logic [4:0] pos_sel;
  logic neg_sel;

  wire logic [4:0] positive_select_set_a =
    input_select_reg[ais_pkg::AIS_POS_A_LSB +: 5];
  wire logic [4:0] positive_select_set_b =
    input_select_reg[ais_pkg::AIS_POS_B_LSB +: 5];
  wire logic negative_select_set_a =
    input_select_reg[ais_pkg::AIS_NEG_A_BIT];
  wire logic negative_select_set_b =
    input_select_reg[ais_pkg::AIS_NEG_B_BIT];
  wire logic scan_enable = control_reg[ais_pkg::AIS_SCAN_EN_BIT];
  wire logic alternate_sample_select = control_reg[ais_pkg::AIS_ALT_BIT];
  wire logic [7:0] conv_clock_divider = control_reg[7:0];

  // decode of a positive select code to channel index; both muxes share it
  function automatic logic [4:0] ais_decode_pos(input logic [4:0] code);
    logic [4:0] ch;
    ch = code;
    if (code == ais_pkg::AIS_CODE_FULL_GAP) begin
      ch = ais_pkg::AIS_CH_FULL_GAP;
    end else if (code == ais_pkg::AIS_CODE_HALF_GAP) begin
      ch = ais_pkg::AIS_CH_HALF_GAP;
    end else if (code > ais_pkg::AIS_CODE_MAX_PIN) begin
      // unused codes: software must not program them, park on input 0
      ch = 5'h00;
    end
    return ch;
  endfunction

  // next selected channel above cur, wrapping to the lowest selected
  function automatic logic [4:0] ais_next_scan(input logic [4:0] cur,
                                               input logic [17:0] set);
    logic [4:0] res;
    logic found;
    res = cur;
    found = 1'b0;
    for (int i = 1; i <= ais_pkg::AIS_NUM_CH; i++) begin
      int idx;
      idx = (int'(cur) + i) % ais_pkg::AIS_NUM_CH;
      if (!found && set[idx]) begin
        res = 5'(idx);
        found = 1'b1;
      end
    end
    return res;
  endfunction

  // gap channels need both the config enable and the scan select
  assign scan_set = {scan_select_high_reg[1] & pin_analog_config_high_reg[1],
                     scan_select_high_reg[0] & pin_analog_config_high_reg[0],
                     scan_select_low_reg};

  // apb decode
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !pwrite && !penable;

  always_comb begin
    addr_ok = 1'b1;
    if (paddr == ais_pkg::AIS_OFF_INPUT_SELECT) begin
      addr_ok = 1'b1;
    end else if (paddr == ais_pkg::AIS_OFF_PCFG_LOW) begin
      addr_ok = 1'b1;
    end else if (paddr == ais_pkg::AIS_OFF_PCFG_HIGH) begin
      addr_ok = 1'b1;
    end else if (paddr == ais_pkg::AIS_OFF_SCAN_LOW) begin
      addr_ok = 1'b1;
    end else if (paddr == ais_pkg::AIS_OFF_SCAN_HIGH) begin
      addr_ok = 1'b1;
    end else if (paddr == ais_pkg::AIS_OFF_CONTROL) begin
      addr_ok = 1'b1;
    end else if (paddr == ais_pkg::AIS_OFF_STATUS) begin
      addr_ok = 1'b1;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // writes land on the access phase; unimplemented bits never store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_select_reg <= ais_pkg::AIS_RESET_VALUE;
      pin_analog_config_low_reg <= ais_pkg::AIS_RESET_VALUE;
      pin_analog_config_high_reg <= ais_pkg::AIS_RESET_VALUE;
      scan_select_low_reg <= ais_pkg::AIS_RESET_VALUE;
      scan_select_high_reg <= ais_pkg::AIS_RESET_VALUE;
      control_reg <= ais_pkg::AIS_RESET_VALUE;
    end else if (wr_en) begin
      if (paddr == ais_pkg::AIS_OFF_INPUT_SELECT) begin
        input_select_reg <= pwdata[15:0] &
          ais_pkg::AIS_MASK_INPUT_SELECT;
      end else if (paddr == ais_pkg::AIS_OFF_PCFG_LOW) begin
        pin_analog_config_low_reg <= pwdata[15:0];
      end else if (paddr == ais_pkg::AIS_OFF_PCFG_HIGH) begin
        pin_analog_config_high_reg <= pwdata[15:0] & ais_pkg::AIS_MASK_HIGH;
      end else if (paddr == ais_pkg::AIS_OFF_SCAN_LOW) begin
        scan_select_low_reg <= pwdata[15:0];
      end else if (paddr == ais_pkg::AIS_OFF_SCAN_HIGH) begin
        scan_select_high_reg <= pwdata[15:0] & ais_pkg::AIS_MASK_HIGH;
      end else if (paddr == ais_pkg::AIS_OFF_CONTROL) begin
        control_reg <= pwdata[15:0] & ais_pkg::AIS_MASK_CONTROL;
      end
    end
  end

  // read data registered in setup so it is valid during the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      if (paddr == ais_pkg::AIS_OFF_INPUT_SELECT) begin
        prdata <= {16'h0000, input_select_reg};
      end else if (paddr == ais_pkg::AIS_OFF_PCFG_LOW) begin
        prdata <= {16'h0000, pin_analog_config_low_reg};
      end else if (paddr == ais_pkg::AIS_OFF_PCFG_HIGH) begin
        prdata <= {16'h0000, pin_analog_config_high_reg};
      end else if (paddr == ais_pkg::AIS_OFF_SCAN_LOW) begin
        prdata <= {16'h0000, scan_select_low_reg};
      end else if (paddr == ais_pkg::AIS_OFF_SCAN_HIGH) begin
        prdata <= {16'h0000, scan_select_high_reg};
      end else if (paddr == ais_pkg::AIS_OFF_CONTROL) begin
        prdata <= {16'h0000, control_reg};
      end else if (paddr == ais_pkg::AIS_OFF_STATUS) begin
        prdata <= {25'h0000000, use_b_reg, neg_sel, pos_sel};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // no wait states: pready in the first access phase cycle only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  // pointer holds the last channel sampled; idle value 17 makes the
  // next pick the lowest selected, even when the full gap is selected
  assign scan_cur = ais_next_scan(scan_ch_reg, scan_set);

  // scan pointer steps once per finished sample of mux A
  always_comb begin
    scan_ch_next = scan_ch_reg;
    if (!scan_enable) begin
      scan_ch_next = 5'(ais_pkg::AIS_NUM_CH - 1);
    end else if (sample_done && !use_b_reg) begin
      scan_ch_next = scan_cur;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_ch_reg <= 5'(ais_pkg::AIS_NUM_CH - 1);
    end else begin
      scan_ch_reg <= scan_ch_next;
    end
  end

  // alternate sample: mux A first, then B, A, B ...
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      use_b_reg <= 1'b0;
    end else if (!alternate_sample_select) begin
      use_b_reg <= 1'b0;
    end else if (sample_done) begin
      use_b_reg <= !use_b_reg;
    end
  end

  always_comb begin
    if (use_b_reg) begin
      pos_sel = ais_decode_pos(positive_select_set_b);
      neg_sel = negative_select_set_b;
    end else if (scan_enable) begin
      pos_sel = scan_cur;
      neg_sel = negative_select_set_a;
    end else begin
      pos_sel = ais_decode_pos(positive_select_set_a);
      neg_sel = negative_select_set_a;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      positive_channel <= 5'h00;
      negative_is_input1 <= 1'b0;
      pin_digital_mode_bits <= 16'h0000;
      // pins come out of reset in analog mode, so sampling is on
      pin_analog_sample_en <= ~ais_pkg::AIS_RESET_VALUE;
      conv_clock_tick <= 1'b0;
    end else begin
      positive_channel <= pos_sel;
      negative_is_input1 <= neg_sel;
      pin_digital_mode_bits <= pin_analog_config_low_reg;
      pin_analog_sample_en <= ~pin_analog_config_low_reg;
      conv_clock_tick <= tick_int;
    end
  end

  ais_clk_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .enable(1'b1),
    .divider(conv_clock_divider),
    .tick(tick_int)
  );

  chk_neg_b_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    use_b_reg |=> negative_is_input1 == $past(negative_select_set_b))
    else $error("mux B negative routing wrong");
  chk_neg_a_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    !use_b_reg |=> negative_is_input1 == $past(negative_select_set_a))
    else $error("mux A negative routing wrong");
  chk_full_gap_b: assert property (
    @(posedge pclk) disable iff (!presetn)
    use_b_reg && positive_select_set_b == 5'h1F |=>
    positive_channel == 5'h11)
    else $error("full gap code not decoded");
  chk_fixed_a_pos: assert property (
    @(posedge pclk) disable iff (!presetn)
    !use_b_reg && !scan_enable && positive_select_set_a <= 5'h0F |=>
    positive_channel == $past(positive_select_set_a))
    else $error("mux A positive decode wrong");
  chk_pin_modes: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pin_digital_mode_bits ^ pin_analog_sample_en) == 16'hFFFF)
    else $error("pin mode outputs disagree");
  chk_high_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    pin_analog_config_high_reg[15:2] == 14'h0000 &&
    scan_select_high_reg[15:2] == 14'h0000)
    else $error("unimplemented bits set");
  chk_scan_gap_gated: assert property (
    @(posedge pclk) disable iff (!presetn)
    scan_set[17] == (scan_select_high_reg[1] &&
    pin_analog_config_high_reg[1]))
    else $error("gap scan gating wrong");
  chk_scan_selected: assert property (
    @(posedge pclk) disable iff (!presetn)
    scan_enable && !use_b_reg && |scan_set |-> scan_set[pos_sel])
    else $error("scan on unselected channel");
  chk_scan_step: assert property (
    @(posedge pclk) disable iff (!presetn)
    scan_enable && sample_done && !use_b_reg && |scan_set &&
    scan_cur < 5'h11 && scan_set[scan_cur + 5'h01] |=>
    scan_cur == $past(scan_cur) + 5'h01)
    else $error("scan did not step ascending");
  chk_alt_toggle: assert property (
    @(posedge pclk) disable iff (!presetn)
    alternate_sample_select && sample_done |=> use_b_reg != $past(use_b_reg))
    else $error("alternate sample did not toggle");

  cov_scan: cover property (@(posedge pclk) scan_enable && sample_done);
  cov_alt_b: cover property (@(posedge pclk) use_b_reg && sample_done);
  cov_half_gap: cover property (@(posedge pclk) positive_channel == 5'h10);
  cov_wrap: cover property (@(posedge pclk)
    sample_done && scan_ch_next < scan_ch_reg);
endmodule

// ### verification/testbench.sv
// self-checking bench for the input select and scan block
`timescale 1ns/1ns
module testbench;
  logic pclk, presetn, psel, penable, pwrite, sample_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic pready, pslverr, negative_is_input1, conv_clock_tick;
  logic [4:0] positive_channel;
  logic [4:0] exp_ch;
  logic [15:0] pin_digital_mode_bits, pin_analog_sample_en;
  logic [32:0] exp_q[$];
  int errors = 0;
  int tests_run = 0;
  integer seed = 34;
  logic [11:0] offs [6] = '{ais_pkg::AIS_OFF_INPUT_SELECT,
    ais_pkg::AIS_OFF_PCFG_LOW, ais_pkg::AIS_OFF_PCFG_HIGH,
    ais_pkg::AIS_OFF_SCAN_LOW, ais_pkg::AIS_OFF_SCAN_HIGH,
    ais_pkg::AIS_OFF_CONTROL};
  logic [15:0] masks [6] = '{16'h9F9F, 16'hFFFF, 16'h0003, 16'hFFFF,
    16'h0003, 16'h03FF};

  ais_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .sample_done(sample_done), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .positive_channel(positive_channel),
    .negative_is_input1(negative_is_input1),
    .pin_digital_mode_bits(pin_digital_mode_bits),
    .pin_analog_sample_en(pin_analog_sample_en),
    .conv_clock_tick(conv_clock_tick));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_read(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // read results are judged here, against the oldest note of the driver
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) begin
        check_read({pslverr, prdata}, 33'hX);
      end else begin
        check_read({pslverr, prdata}, exp_q.pop_front());
      end
    end
  end

  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(a, 1'b0, 32'h0);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic settle;
    repeat (3) @(posedge pclk);
  endtask

  task automatic pulse;
    @(posedge pclk);
    sample_done <= 1'b1;
    @(posedge pclk);
    sample_done <= 1'b0;
    settle();
  endtask

  task automatic chan(input logic [4:0] c, input logic n);
    check_val({10'h0, negative_is_input1, positive_channel},
              {10'h0, n, c});
  endtask

  task automatic period(input logic [7:0] d);
    int n;
    wr(ais_pkg::AIS_OFF_CONTROL, {24'h0, d});
    // let ticks of the old divider drain before timing a period
    settle();
    n = 0;
    while (conv_clock_tick !== 1'b1 && n < 600) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (conv_clock_tick !== 1'b1 && n < 600);
    check_val(16'(n), 16'(d) + 16'h0001);
  endtask

  initial begin
    #200000;
    errors++;
    summarize();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sample_done = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) rd(12'(4 * i), 33'h0);
    check_val(pin_analog_sample_en, 16'hFFFF);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      wr(offs[i], 32'hFFFFFFFF);
      rd(offs[i], {17'h0, masks[i]});
      wr(offs[i], 32'h0);
    end
    // unmapped word: refused, reads zero
    rd(12'h01C, {1'b1, 32'h0});
    wr(12'h01C, 32'hFFFF);
    $display("test registers done");
    for (int c = 0; c < 32; c++) begin
      if (c < 16 || c > 29) begin
        rnd = $random(seed);
        wr(ais_pkg::AIS_OFF_INPUT_SELECT, {24'h0, rnd[0], 2'b0, 5'(c)});
        settle();
        exp_ch = c < 16 ? 5'(c) : (c == 30 ? 5'h10 : 5'h11);
        chan(exp_ch, rnd[0]);
      end
    end
    $display("test decode done");
    wr(ais_pkg::AIS_OFF_INPUT_SELECT, 32'h9F03);
    wr(ais_pkg::AIS_OFF_CONTROL, 32'h200);
    settle();
    chan(5'h03, 1'b0);
    pulse();
    chan(5'h11, 1'b1);
    pulse();
    chan(5'h03, 1'b0);
    wr(ais_pkg::AIS_OFF_INPUT_SELECT, 32'h0E9E);
    settle();
    chan(5'h10, 1'b1);
    pulse();
    chan(5'h0E, 1'b0);
    wr(ais_pkg::AIS_OFF_CONTROL, 32'h0);
    $display("test alternate done");
    repeat (3) begin
      rnd = $random(seed);
      wr(ais_pkg::AIS_OFF_PCFG_LOW, rnd);
      settle();
      check_val(pin_digital_mode_bits, rnd[15:0]);
      check_val(pin_analog_sample_en, ~rnd[15:0]);
    end
    $display("test pin config done");
    // full gap enabled and selected, half gap enabled only
    wr(ais_pkg::AIS_OFF_SCAN_LOW, 32'h0024);
    wr(ais_pkg::AIS_OFF_PCFG_HIGH, 32'h3);
    wr(ais_pkg::AIS_OFF_SCAN_HIGH, 32'h2);
    wr(ais_pkg::AIS_OFF_CONTROL, 32'h100);
    settle();
    chan(5'h02, 1'b1);
    pulse();
    chan(5'h05, 1'b1);
    pulse();
    chan(5'h11, 1'b1);
    pulse();
    chan(5'h02, 1'b1);
    wr(ais_pkg::AIS_OFF_PCFG_HIGH, 32'h1);
    pulse();
    chan(5'h05, 1'b1);
    pulse();
    chan(5'h02, 1'b1);
    wr(ais_pkg::AIS_OFF_CONTROL, 32'h0);
    $display("test scan done");
    rnd = $random(seed);
    period(8'h00);
    period(8'h03);
    period(rnd[7:0]);
    $display("test divider done");
    summarize();
  end
endmodule
